/* File: src/lpt_pkg.sv */
// constants, register map and carrier types of the printer port
package lpt_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CONTROL = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  // control register fields
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFEED = 1;
  localparam int CTL_SELECT = 3;
  localparam int CTL_DIR_IN = 5;
  localparam int CTL_PORT_EN = 6;
  localparam logic [7:0] CTL_WMASK = 8'h6b;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // status register fields
  localparam int ST_FAULT_N = 3;
  localparam int ST_SELECTED = 4;
  localparam int ST_PAPER_OUT = 5;
  localparam int ST_ACK_N = 6;
  localparam int ST_BUSY = 7;
  // interrupt status and mask fields
  localparam int EV_ACK = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_PAPER = 2;
  localparam int EV_READY = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_RESET = 4'h0;
  // synchroniser depth and bus answer latency
  localparam int SYNC_STAGES = 2;
  localparam int ANSWER_CYCLES = 1;

  // sensed printer inputs, as seen on the pins
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out;
    logic selected;
    logic fault_n;
  } printer_status_t;

  // handshake outputs toward the printer
  typedef struct packed {
    logic select_request_n;
    logic auto_feed_n;
    logic data_strobe_n;
  } printer_ctrl_t;

  // bus answer machine, gray coded
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;
endpackage

/* File: src/sync_stage.sv */
// multi-bit two-flop synchroniser with clock enable
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) begin
      $error("sync_stage width must be positive");
    end
  end

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{RESET_VAL}};
      q_o <= {WIDTH{RESET_VAL}};
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

/* File: src/printer_port.sv */
// printer parallel port: avalon register slave, pin drive and sensing
`timescale 1ns/1ps
module printer_port
  import lpt_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt
  output logic irq_o,
  // printer status inputs
  input wire lpt_pkg::printer_status_t printer_status_i,
  // printer handshake outputs
  output lpt_pkg::printer_ctrl_t printer_ctrl_o,
  // print data bus, three signals per line
  input wire logic [DATA_W-1:0] print_data_bus_i,
  output logic [DATA_W-1:0] print_data_bus_o,
  output logic [DATA_W-1:0] print_data_bus_oe_o
);
  import lpt_pkg::*;

  initial begin
    if (DATA_W != 8) begin
      $error("printer_port serves a byte-wide data bus only");
    end
  end

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr[4:2] == off[4:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic rst_n;
  printer_status_t st_s;
  logic [DATA_W-1:0] bus_s;

  sync_stage #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(1'b1),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // printer levels are asynchronous to clk_i
  sync_stage #(.WIDTH(5), .RESET_VAL(1'b0)) u_st_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .d_i(printer_status_i),
    .q_o(st_s)
  );

  sync_stage #(.WIDTH(DATA_W), .RESET_VAL(1'b0)) u_bus_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .d_i(print_data_bus_i),
    .q_o(bus_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a single-cycle answer
  bus_state_t state_r;
  bus_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [DATA_W-1:0] data_r;
  logic [EV_W-1:0] ev_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] ev_read_r;
  printer_status_t st_prev_r;

  wire req = avs_read_i | avs_write_i;
  wire take = (state_r == BUS_IDLE) & req;
  wire done = (state_r == BUS_ANSWER);
  wire wr_done = done & avs_write_i & avs_byteenable_i[0];
  wire rd_done = done & avs_read_i;
  wire wr_data = wr_done & hit(avs_address_i, OFF_DATA);
  wire wr_ctrl = wr_done & hit(avs_address_i, OFF_CONTROL);
  wire wr_mask = wr_done & hit(avs_address_i, OFF_IRQ_MASK);
  wire rd_evst = rd_done & hit(avs_address_i, OFF_IRQ_STATUS);

  assign state_nxt = take ? BUS_ANSWER : BUS_IDLE;

  // readback sources
  wire dir_in = ctrl_r[CTL_DIR_IN];
  wire [7:0] status_byte = {st_s.busy, st_s.ack_n, st_s.paper_out, st_s.selected,
                            st_s.fault_n, 3'h0};
  wire [7:0] ctrl_byte = {1'b0, ctrl_r[6:5], 1'b0, ~printer_ctrl_o.select_request_n,
                          1'b0, ~printer_ctrl_o.auto_feed_n, ~printer_ctrl_o.data_strobe_n};
  wire [7:0] data_byte = dir_in ? bus_s : data_r;
  wire sel_data = hit(avs_address_i, OFF_DATA);
  wire sel_stat = hit(avs_address_i, OFF_STATUS);
  wire sel_ctrl = hit(avs_address_i, OFF_CONTROL);
  wire sel_evst = hit(avs_address_i, OFF_IRQ_STATUS);
  wire sel_mask = hit(avs_address_i, OFF_IRQ_MASK);
  // unmapped offsets answer zero
  wire [7:0] rd_byte = sel_data ? data_byte :
                       sel_stat ? status_byte :
                       sel_ctrl ? ctrl_byte :
                       sel_evst ? {4'h0, ev_r} :
                       sel_mask ? {4'h0, mask_r} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // printer events, sticky until read
  logic [EV_W-1:0] ev_in;
  assign ev_in[EV_ACK] = st_prev_r.ack_n & ~st_s.ack_n;
  assign ev_in[EV_FAULT] = st_prev_r.fault_n & ~st_s.fault_n;
  assign ev_in[EV_PAPER] = ~st_prev_r.paper_out & st_s.paper_out;
  assign ev_in[EV_READY] = st_prev_r.busy & ~st_s.busy;
  // a read clears only what it reported; a same-cycle event survives
  wire [EV_W-1:0] ev_nxt = (ev_r & ~(rd_evst ? ev_read_r : EV_RESET)) | ev_in;
  wire [EV_W-1:0] mask_nxt = wr_mask ? avs_writedata_i[EV_W-1:0] : mask_r;
  wire [7:0] ctrl_nxt = wr_ctrl ? (avs_writedata_i[7:0] & CTL_WMASK) : ctrl_r;
  wire drive_en = ctrl_nxt[CTL_PORT_EN] & ~ctrl_nxt[CTL_DIR_IN];

  ////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      ev_read_r <= EV_RESET;
    end else if (ce_i) begin
      state_r <= state_nxt;
      avs_waitrequest_o <= ~take;
      if (take) begin
        avs_readdata_o <= {24'h00_0000, rd_byte};
        // clear exactly what the answer reports; later events stay set
        ev_read_r <= ev_r;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTL_RESET;
      data_r <= '0;
      ev_r <= EV_RESET;
      mask_r <= EV_RESET;
      irq_o <= 1'b0;
      st_prev_r <= '0;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      if (wr_data) begin
        data_r <= avs_writedata_i[DATA_W-1:0];
      end
      ev_r <= ev_nxt;
      mask_r <= mask_nxt;
      irq_o <= |(ev_nxt & mask_nxt);
      st_prev_r <= st_s;
    end
  end

  // handshake pins follow the control register, inverted; the data bus follows the data register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      printer_ctrl_o <= '1;
      print_data_bus_o <= '0;
      print_data_bus_oe_o <= '0;
    end else if (ce_i) begin
      printer_ctrl_o.select_request_n <= ~ctrl_nxt[CTL_SELECT];
      printer_ctrl_o.auto_feed_n <= ~ctrl_nxt[CTL_AUTOFEED];
      printer_ctrl_o.data_strobe_n <= ~ctrl_nxt[CTL_STROBE];
      // software paces bytes against busy; nothing is queued here
      print_data_bus_o <= wr_data ? avs_writedata_i[DATA_W-1:0] : data_r;
      print_data_bus_oe_o <= {DATA_W{drive_en}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_select_pin;
    wr_ctrl && ce_i |=> printer_ctrl_o.select_request_n == !$past(avs_writedata_i[3]);
  endproperty
  a_select_pin: assert property (p_select_pin) else $error("select pin mismatch");

  property p_autofeed_pin;
    wr_ctrl && ce_i |=> printer_ctrl_o.auto_feed_n == !$past(avs_writedata_i[1]);
  endproperty
  a_autofeed_pin: assert property (p_autofeed_pin) else $error("autofeed pin mismatch");

  property p_strobe_pin;
    wr_ctrl && ce_i |=> printer_ctrl_o.data_strobe_n == !$past(avs_writedata_i[0]);
  endproperty
  a_strobe_pin: assert property (p_strobe_pin) else $error("strobe pin mismatch");

  property p_float;
    print_data_bus_oe_o != '0 |-> ctrl_r[CTL_PORT_EN] && !ctrl_r[CTL_DIR_IN];
  endproperty
  a_float: assert property (p_float) else $error("bus driven while deselected");

  property p_bus_in;
    take && ce_i && sel_data && dir_in |=> avs_readdata_o[7:0] == $past(bus_s);
  endproperty
  a_bus_in: assert property (p_bus_in) else $error("input byte not returned");

  property p_sel_sync;
    ce_i [*3] ##0 $stable(printer_status_i.selected) [*3] ##0 take && sel_stat
      |=> avs_readdata_o[ST_SELECTED] == $past(printer_status_i.selected, 1);
  endproperty
  a_sel_sync: assert property (p_sel_sync) else $error("selected level wrong");

  property p_fault_bit;
    ce_i [*3] ##0 $stable(printer_status_i.fault_n) [*3] ##0 take && sel_stat
      |=> avs_readdata_o[ST_FAULT_N] == $past(printer_status_i.fault_n, 1);
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit wrong");

  property p_answer;
    take && ce_i |=> !avs_waitrequest_o ##1 (avs_waitrequest_o || !ce_i);
  endproperty
  a_answer: assert property (p_answer) else $error("waitrequest timing wrong");

  property p_irq;
    ce_i && (ev_in & mask_r & ~mask_nxt) == '0 && (ev_in & mask_r) != '0 |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event gave no interrupt");

  c_ctrl_write: cover property (wr_ctrl);
  c_ack_event: cover property (ev_in[EV_ACK] && mask_r[EV_ACK]);
  c_input_read: cover property (rd_done && sel_data && dir_in);
  c_evst_read: cover property (rd_evst && ev_r != '0);
endmodule

/* File: verif/line_printer_model.sv */
// behavioural line printer on the far side of the port
`timescale 1ns/1ps
module line_printer_model
  import lpt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins from the port
  input wire lpt_pkg::printer_ctrl_t ctrl_i,
  input wire logic [7:0] data_i,
  // scenario commands
  input wire logic fault_i,
  input wire logic paper_i,
  input wire logic [3:0] busy_len_i,
  // pins to the port and captured byte
  output lpt_pkg::printer_status_t status_o,
  output logic [7:0] byte_o
);
  logic [3:0] cnt_r;
  logic strobe_q;
  ////////////////////////////////////////////////////////////////////////
  // a strobe while busy is ignored, as a real printer would
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
      strobe_q <= 1'b1;
      byte_o <= 8'h00;
    end else begin
      strobe_q <= ctrl_i.data_strobe_n;
      if (strobe_q && !ctrl_i.data_strobe_n && cnt_r == 4'h0) begin
        byte_o <= data_i;
        cnt_r <= busy_len_i;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  assign status_o.busy = (cnt_r > 4'h1);
  assign status_o.ack_n = (cnt_r != 4'h1);
  assign status_o.selected = ~ctrl_i.select_request_n;
  assign status_o.paper_out = paper_i;
  assign status_o.fault_n = ~fault_i;
endmodule

/* File: verif/printer_port_tb_top.sv */
// self-checking bench of the printer port against the printer model
`timescale 1ns/1ps
module printer_port_tb_top;
  import lpt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  printer_status_t stat;
  printer_ctrl_t ctrl;
  logic [7:0] pd_o, pd_oe, pd_i, got_byte, v, d;
  logic [7:0] far_byte = 8'h00;
  logic fault = 1'b0;
  logic paper = 1'b0;
  logic ce = 1'b1;
  logic [3:0] busy_len = 4'h3;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int checks = 0;
  // undriven lines carry a changing far-side byte, never a stale one
  assign pd_i = (pd_o & pd_oe) | (far_byte & ~pd_oe);
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  printer_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_byteenable_i(4'hf), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .irq_o(irq), .printer_status_i(stat),
    .printer_ctrl_o(ctrl), .print_data_bus_i(pd_i), .print_data_bus_o(pd_o),
    .print_data_bus_oe_o(pd_oe));
  line_printer_model u_printer (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
    .data_i(pd_i), .fault_i(fault), .paper_i(paper), .busy_len_i(busy_len),
    .status_o(stat), .byte_o(got_byte));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] dv);
    int n;
    @(posedge clk_i);
    addr <= a;
    wdata <= {24'h0, dv};
    wr_en <= w;
    rd_en <= ~w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    acc(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq !== e && n < 200);
    check({31'h0, irq}, {31'h0, e});
    if (irq !== e) begin
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // read data stand at the edge where waitrequest is seen low
  always @(posedge clk_i) begin
    if (rd_en && wait_req === 1'b0) begin
      check(rdata, exp_q.pop_front());
    end
  end
  initial begin
    #2000000;
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h5435));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({24'h0, pd_oe}, 32'h0);
    check({29'h0, ctrl}, 32'h7);
    rd(OFF_IRQ_STATUS, 8'h00);
    acc(1'b1, 5'h14, 8'hff);
    rd(5'h14, 8'h00);
    d = 8'($urandom());
    acc(1'b1, OFF_DATA, d);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom()) & 8'h6a;
      far_byte <= 8'($urandom());
      acc(1'b1, OFF_CONTROL, v);
      @(negedge clk_i);
      check({29'h0, ctrl}, {29'h0, ~v[3], ~v[1], 1'b1});
      check({24'h0, pd_oe}, (v[6] && !v[5]) ? 32'hff : 32'h0);
      repeat (3) @(posedge clk_i);
      rd(OFF_CONTROL, v);
      rd(OFF_STATUS, {3'b010, v[3], 1'b1, 3'b000});
      rd(OFF_DATA, v[5] ? far_byte : d);
    end
    $display("test control pins done");
    acc(1'b1, OFF_IRQ_MASK, 8'h09);
    rd(OFF_IRQ_STATUS, 8'h00);
    rd(OFF_STATUS, {3'b010, v[3], 1'b1, 3'b000});
    v = 8'($urandom());
    busy_len <= 4'($urandom_range(15, 3));
    acc(1'b1, OFF_DATA, v);
    acc(1'b1, OFF_CONTROL, 8'h41);
    @(negedge clk_i);
    check({29'h0, ctrl}, 32'h6);
    check({24'h0, pd_o}, {24'h0, v});
    acc(1'b1, OFF_CONTROL, 8'h40);
    wait_irq(1'b1);
    check({24'h0, got_byte}, {24'h0, v});
    rd(OFF_IRQ_STATUS, 8'h09);
    wait_irq(1'b0);
    $display("test print byte done");
    acc(1'b1, OFF_IRQ_MASK, 8'h00);
    fault <= 1'b1;
    paper <= 1'b1;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    check({31'h0, irq}, 32'h0);
    rd(OFF_STATUS, 8'h60);
    acc(1'b1, OFF_IRQ_MASK, 8'h04);
    wait_irq(1'b1);
    rd(OFF_IRQ_STATUS, 8'h06);
    wait_irq(1'b0);
    $display("test fault and paper done");
    @(posedge clk_i);
    paper <= 1'b0;
    repeat (6) @(posedge clk_i);
    // frozen port must not see the new paper level
    ce <= 1'b0;
    paper <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check({31'h0, irq}, 32'h0);
    @(posedge clk_i);
    ce <= 1'b1;
    wait_irq(1'b1);
    rd(OFF_IRQ_STATUS, 8'h04);
    wait_irq(1'b0);
    $display("test clock enable done");
    summarize();
  end
endmodule
